//--- include/oled_gfx_pkg.sv
package oled_gfx_pkg;
    // ************************************************************
    // register map, byte addresses of aligned words
    // ************************************************************
    localparam int unsigned ADDR_W     = 5;
    localparam logic [4:0]  OFS_CMD    = 5'h00; // write: command or data byte
    localparam logic [4:0]  OFS_STATUS = 5'h04; // mode and lock state
    localparam logic [4:0]  OFS_WINDOW = 5'h08; // column and page windows
    localparam logic [4:0]  OFS_VSCRL  = 5'h0C; // start line, offset, scroll area
    localparam logic [4:0]  OFS_HSCRL  = 5'h10; // horizontal scroll setup
    localparam int unsigned DC_BIT     = 8;     // command word: data/command select

    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [7:0] OP_MODE_SEL  = 8'hF0;
    localparam logic [7:0] OP_ADDR_MODE = 8'h20;
    localparam logic [7:0] OP_COL_ADDR  = 8'h21;
    localparam logic [7:0] OP_PAGE_ADDR = 8'h22;
    localparam logic [7:0] OP_VAREA     = 8'hA3;
    localparam logic [7:0] OP_OFFSET    = 8'hD3;
    localparam logic [7:0] OP_HS_RIGHT  = 8'h26;
    localparam logic [7:0] OP_HS_LEFT   = 8'h27;
    localparam logic [7:0] OP_VH_RIGHT  = 8'h29;
    localparam logic [7:0] OP_VH_LEFT   = 8'h2A;
    localparam logic [7:0] OP_CS_RIGHT  = 8'h2C;
    localparam logic [7:0] OP_CS_LEFT   = 8'h2D;
    localparam logic [3:0] NIB_COL_LO   = 4'h0;  // 00..0F
    localparam logic [4:0] PFX_COL_HI   = 5'h02; // 10..17
    localparam logic [3:0] NIB_LINE     = 4'h4;  // 40..4F
    localparam logic [6:0] PFX_ENTIRE   = 7'h52; // A4/A5
    localparam logic [6:0] PFX_PAGE     = 7'h58; // B0/B1
    localparam logic [6:0] PFX_UNLOCK   = 7'h3C; // 78/79
    localparam logic [2:0] PFX_FUNC_SET = 3'h1;  // 001x_xxxx
    localparam int unsigned FUNC_EXT_BIT = 2;

    // ************************************************************
    // parameter counts and reset values
    // ************************************************************
    localparam logic [2:0] NPAR_ONE    = 3'h1;
    localparam logic [2:0] NPAR_TWO    = 3'h2;
    localparam logic [2:0] NPAR_SCROLL = 3'h7;
    localparam logic [1:0] AM_HORIZ    = 2'h0;
    localparam logic [1:0] AM_VERT     = 2'h1;
    localparam logic [1:0] AM_PAGE     = 2'h2;
    localparam logic [1:0] AM_INVALID  = 2'h3;
    localparam logic [6:0] COL_END_RST = 7'h77; // 119
    localparam logic [4:0] ROWS_RST    = 5'h10; // 16
    localparam logic [7:0] FRAMES_RST  = 8'h06;

    // scroll step interval code to frame count
    function automatic logic [7:0] step_frames(input logic [2:0] code);
        unique case (code)
            3'h0: step_frames = 8'h06;
            3'h1: step_frames = 8'h20;
            3'h2: step_frames = 8'h40;
            3'h3: step_frames = 8'h80;
            3'h4: step_frames = 8'h03;
            3'h5: step_frames = 8'h04;
            3'h6: step_frames = 8'h05;
            3'h7: step_frames = 8'h02;
        endcase
    endfunction : step_frames
endpackage : oled_gfx_pkg

//--- testbench/host_cmd_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_cmd_model (
    input  wire logic                            mclk,        // bus clock
    input  wire logic                            waitrequest, // slave stall
    input  wire logic [31:0]                     readdata,    // slave read data
    output var  logic [oled_gfx_pkg::ADDR_W-1:0] address,     // byte address
    output var  logic                            read,        // read request
    output var  logic                            write,       // write request
    output var  logic [3:0]                      byteenable,  // byte lanes
    output var  logic [31:0]                     writedata    // write data
);
    import oled_gfx_pkg::*;

    // idle bus at time zero
    initial begin
        address    = 5'h00;
        read       = 1'b0;
        write      = 1'b0;
        byteenable = 4'hF;
        writedata  = 32'h00000000;
    end

    // ************************************************************
    // one bus cycle, request held until waitrequest is seen low
    // ************************************************************
    task automatic busXfer(input logic [ADDR_W-1:0] a, input logic isWr,
                           input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        address   <= a;
        read      <= ~isWr;
        write     <= isWr;
        writedata <= d;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        // released lines show the inverse so a stale value never looks valid
        read      <= 1'b0;
        write     <= 1'b0;
        address   <= ~a;
        writedata <= ~d;
    endtask : busXfer

    // one byte on the command stream, opcode and parameters alike in order
    task automatic cmd(input logic [7:0] b, input logic isData);
        logic [31:0] q;
        busXfer(OFS_CMD, 1'b1, {23'h000000, isData, b}, q);
    endtask : cmd
endmodule : host_cmd_model
`default_nettype wire

//--- testbench/oled_graphic_command_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module oled_graphic_command_decoder_tb;
    import oled_gfx_pkg::*;

    // ************************************************************
    // signals and bookkeeping
    // ************************************************************
    logic              mclk;
    logic              rst;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
    logic              waitrequest;
    logic [31:0]       readdata;
    logic              charMode;
    logic              entireOn;
    logic              contentStep;
    logic              contentLeft;
    logic [7:0]        stepFrames;
    int                mismatches = 0;
    int                checksDone = 0;
    int                cycleCount = 0;
    localparam int     CYCLE_LIMIT = 20000;
    logic [7:0]        frameTab [8] = '{8'h06, 8'h20, 8'h40, 8'h80, 8'h03, 8'h04, 8'h05, 8'h02};
    logic [1:0]        amCode [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [1:0]        amExp [4] = '{2'h0, 2'h1, 2'h1, 2'h2};

    oled_graphic_command_decoder #(.MUX_RATIO(16)) dut_u (
        .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .waitrequest(waitrequest),
        .readdata(readdata), .charMode(charMode), .entireOn(entireOn),
        .contentStep(contentStep), .contentLeft(contentLeft), .stepFrames(stepFrames));

    host_cmd_model host_u (
        .mclk(mclk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk) begin
        cycleCount++;
        if (cycleCount == CYCLE_LIMIT) begin
            mismatches++;
            summarize();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        host_u.busXfer(a, 1'b0, 32'h00000000, q);
        chk(q, e);
    endtask : rd

    // sends n command bytes, most significant first
    task automatic send(input logic [63:0] s, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            host_u.cmd(s[8*k +: 8], 1'b0);
        end
    endtask : send

    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk({charMode, entireOn, contentStep, contentLeft, stepFrames}, 12'h806);
        rd(OFS_STATUS, 32'h00000005);
        rd(OFS_WINDOW, 32'h02770000);
        rd(OFS_VSCRL, 32'h06010000);
        rd(5'h14, 32'h00000000);
        $display("test reset done");
        send(64'hF0_00_A5, 3);
        #1;
        chk({charMode, entireOn}, 2'h2);
        send(64'h3C_79, 2);
        rd(OFS_STATUS, 32'h00000035);
        for (int i = 0; i < 3; i++) begin
            send({56'h0, 8'hF0} << 8 | i[0], 2);
            #1;
            chk(charMode, i[0]);
        end
        for (int i = 0; i < 2; i++) begin
            send(8'hA5 ^ i[7:0], 1);
            #1;
            chk(entireOn, !i[0]);
        end
        host_u.cmd(8'hA5, 1'b1);
        #1;
        chk(entireOn, 1'b0);
        $display("test lock and modes done");
        send(64'h0A_17_B1_21_05_70, 6);
        send(64'h22_01_01, 3);
        rd(OFS_WINDOW, 32'h0770057A);
        for (int i = 0; i < 4; i++) begin
            send({8'h20, 6'h00, amCode[i]}, 2);
            rd(OFS_STATUS, 32'h00000030 | {amExp[i], 1'b0});
        end
        send(64'h4F_D3_09_A3_03_0D, 6);
        send(64'hA3_04_0D, 3);
        rd(OFS_VSCRL, 32'h0600D39F);
        $display("test windows done");
        for (int i = 0; i < 8; i++) begin
            send({8'h26 | {7'h00, i[0]}, 16'h0001, 5'h00, i[2:0], 32'h01001060}, 8);
            #1;
            chk(stepFrames, frameTab[i]);
            rd(OFS_HSCRL, 32'h001C0406 | (i[2:0] << 3) | i[0]);
        end
        for (int i = 0; i < 2; i++) begin
            send({8'h29 + i[7:0], 7'h00, i[0], 48'h0007_0105_0077}, 8);
            rd(OFS_HSCRL, 32'h00AEE03C | i[0] | (i[0] << 20));
        end
        send(64'h2D_00_00_01_00_00_10, 7);
        rd(OFS_STATUS, 32'h00000074);
        chk(contentStep, 1'b0);
        send(64'h20, 1);
        #1;
        chk({contentStep, contentLeft}, 2'h3);
        @(posedge mclk);
        #1;
        chk(contentStep, 1'b0);
        send(64'h2C_00_00_01_00_00_10_20, 8);
        #1;
        chk(contentLeft, 1'b0);
        $display("test scroll done");
        send(64'h78_A5, 2);
        #1;
        chk(entireOn, 1'b0);
        rd(OFS_STATUS, 32'h00000014);
        $display("test relock done");
        summarize();
    end
endmodule : oled_graphic_command_decoder_tb
`default_nettype wire

//--- verilog/oled_graphic_command_decoder.sv
// Notes on behaviour
// - F0 plus one byte: bit 0 low graphic, high character; character after reset.
// - 00..0F load the low nibble of the page-mode column start; reset zero.
// - 10..17 load the high bits of the page-mode column start; reset zero.
// - 20 plus byte picks horizontal, vertical or page mode; page at reset; 11b ignored.
// - 21 plus two bytes sets column start (reset 0) and end (reset 119).
// - 22 plus two bytes sets page start (reset 0) and end (reset 1).
// - 40..4F set display start line 0..15; reset zero.
// - A3 plus two bytes: fixed rows and scroll rows; sum within multiplex ratio.
// - A4 shows RAM content (reset); A5 lights every pixel.
// - B0/B1 select page-mode start page from bit 0.
// - D3 plus byte sets vertical display shift from low nibble; reset zero.
// - 26 sets right, 27 left continuous scroll, one column per step.
// - interval code maps to 6,32,64,128,3,4,5,2 frames.
// - 29/2A set combined scroll; parameter bit 0 gives one-column horizontal offset.
// - 2C/2D shift content one column per command, 2D leftward.
// - while command unlock is clear all these graphic commands are refused.
// - with extended select set, 78 clears and 79 sets command unlock; clear at reset.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module oled_graphic_command_decoder #(
    parameter int unsigned MUX_RATIO = 16
) (
    input  wire logic                              mclk,        // 40 MHz clock
    input  wire logic                              rst,         // async reset, high
    input  wire logic [oled_gfx_pkg::ADDR_W-1:0]   address,     // byte address
    input  wire logic                              read,        // read request
    input  wire logic                              write,       // write request
    input  wire logic [3:0]                        byteenable,  // byte lanes
    input  wire logic [31:0]                       writedata,   // write data
    output logic                                   waitrequest, // stall
    output logic [31:0]                            readdata,    // read data
    output logic                                   charMode,    // character mode
    output logic                                   entireOn,    // all pixels lit
    output logic                                   contentStep, // one-column shift pulse
    output logic                                   contentLeft, // shift direction left
    output logic [7:0]                             stepFrames   // frames per scroll step
);
    import oled_gfx_pkg::*;

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (MUX_RATIO < 1 || MUX_RATIO > 31) begin : g_bad_mux
        $error("MUX_RATIO must lie in 1..31");
    end

    localparam logic [5:0] MUX_LIMIT = 6'(MUX_RATIO);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic             waitReq;
        logic [31:0]      rdData;
        logic             extSel;
        logic             unlock;
        logic             collecting;
        logic [7:0]       opcode;
        logic [2:0]       need;
        logic [2:0]       idx;
        logic [6:0][7:0]  pbuf;
        logic             charMode;
        logic [1:0]       addrMode;
        logic [6:0]       pageCol;
        logic [6:0]       colStart;
        logic [6:0]       colEnd;
        logic             pageStart;
        logic             pageEnd;
        logic             pagePage;
        logic [3:0]       startLine;
        logic [3:0]       dispOffset;
        logic [3:0]       fixedRows;
        logic [4:0]       scrollRows;
        logic             entireOn;
        logic             scrollLeft;
        logic             hsStartPage;
        logic             hsEndPage;
        logic [2:0]       interval;
        logic [7:0]       frames;
        logic [6:0]       hsStartCol;
        logic [6:0]       hsEndCol;
        logic             hOffset;
        logic [3:0]       vOffset;
        logic             contentStep;
        logic             contentLeft;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic       byteTake;
    logic [7:0] byteIn;
    logic       dcIn;

    // command port write accepted at the edge that ends the ready cycle
    assign byteTake = write && !st_r.waitReq && (address == OFS_CMD) && byteenable[0];
    assign byteIn   = writedata[7:0];
    assign dcIn     = byteenable[1] && writedata[DC_BIT];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [6:0][7:0] p;
        logic [5:0]      areaSum;
        p       = st_r.pbuf;
        areaSum = 6'h00;
        st_nxt  = st_r;
        st_nxt.contentStep = 1'b0;
        // one wait cycle, then one ready cycle per request
        st_nxt.waitReq = !((read || write) && st_r.waitReq);
        if (read && st_r.waitReq) begin
            unique case (address)
                OFS_STATUS: st_nxt.rdData = {25'h0000000, st_r.collecting, st_r.unlock,
                                             st_r.extSel, st_r.entireOn, st_r.addrMode,
                                             st_r.charMode};
                OFS_WINDOW: st_nxt.rdData = {5'h00, st_r.pagePage, st_r.pageEnd,
                                             st_r.pageStart, 1'b0, st_r.colEnd, 1'b0,
                                             st_r.colStart, 1'b0, st_r.pageCol};
                OFS_VSCRL:  st_nxt.rdData = {st_r.frames, 7'h00, st_r.scrollRows,
                                             st_r.fixedRows, st_r.dispOffset, st_r.startLine};
                OFS_HSCRL:  st_nxt.rdData = {7'h00, st_r.vOffset, st_r.hOffset,
                                             st_r.hsEndCol, st_r.hsStartCol, st_r.interval,
                                             st_r.hsEndPage, st_r.hsStartPage, st_r.scrollLeft};
                default:    st_nxt.rdData = 32'h00000000; // unmapped and command port
            endcase
        end
        // data bytes go to display RAM, not to this decoder
        if (byteTake && !dcIn) begin
            if (st_r.collecting) begin
                p[st_r.idx] = byteIn;
                st_nxt.pbuf = p;
                if (st_r.idx + 3'h1 == st_r.need) begin
                    st_nxt.collecting = 1'b0;
                    st_nxt.idx        = 3'h0;
                    unique case (st_r.opcode)
                        OP_MODE_SEL:  st_nxt.charMode = p[0][0];
                        OP_ADDR_MODE: begin
                            if (p[0][1:0] != AM_INVALID) begin
                                st_nxt.addrMode = p[0][1:0];
                            end
                        end
                        OP_COL_ADDR: begin
                            st_nxt.colStart = p[0][6:0];
                            st_nxt.colEnd   = p[1][6:0];
                        end
                        OP_PAGE_ADDR: begin
                            st_nxt.pageStart = p[0][0];
                            st_nxt.pageEnd   = p[1][0];
                        end
                        OP_VAREA: begin
                            areaSum = {2'b00, p[0][3:0]} + {1'b0, p[1][4:0]};
                            if (areaSum <= MUX_LIMIT) begin
                                st_nxt.fixedRows  = p[0][3:0];
                                st_nxt.scrollRows = p[1][4:0];
                            end
                        end
                        OP_OFFSET: st_nxt.dispOffset = p[0][3:0];
                        default: begin
                            // scroll setups share one seven-byte layout
                            st_nxt.hsStartPage = p[1][0];
                            st_nxt.hsEndPage   = p[3][0];
                            st_nxt.hsStartCol  = p[5][6:0];
                            st_nxt.hsEndCol    = p[6][6:0];
                            if (st_r.opcode == OP_CS_RIGHT || st_r.opcode == OP_CS_LEFT) begin
                                st_nxt.contentStep = 1'b1;
                                st_nxt.contentLeft = st_r.opcode[0];
                            end else begin
                                st_nxt.interval = p[2][2:0];
                                st_nxt.frames   = step_frames(p[2][2:0]);
                                if (st_r.opcode == OP_HS_RIGHT || st_r.opcode == OP_HS_LEFT) begin
                                    st_nxt.scrollLeft = st_r.opcode[0];
                                    st_nxt.hOffset    = 1'b1;
                                end else begin
                                    st_nxt.scrollLeft = st_r.opcode[1];
                                    st_nxt.hOffset    = p[0][0];
                                    st_nxt.vOffset    = p[4][3:0];
                                end
                            end
                        end
                    endcase
                end else begin
                    st_nxt.idx = st_r.idx + 3'h1;
                end
            end else if (st_r.extSel && byteIn[7:1] == PFX_UNLOCK) begin
                st_nxt.unlock = byteIn[0];
            end else if (!st_r.unlock) begin
                // locked: only the fundamental function set is seen here
                if (byteIn[7:5] == PFX_FUNC_SET) begin
                    st_nxt.extSel = byteIn[FUNC_EXT_BIT];
                end
            end else begin
                st_nxt.opcode = byteIn;
                st_nxt.idx    = 3'h0;
                unique case (byteIn)
                    OP_MODE_SEL, OP_ADDR_MODE, OP_OFFSET: begin
                        st_nxt.collecting = 1'b1;
                        st_nxt.need       = NPAR_ONE;
                    end
                    OP_COL_ADDR, OP_PAGE_ADDR, OP_VAREA: begin
                        st_nxt.collecting = 1'b1;
                        st_nxt.need       = NPAR_TWO;
                    end
                    OP_HS_RIGHT, OP_HS_LEFT, OP_VH_RIGHT, OP_VH_LEFT,
                    OP_CS_RIGHT, OP_CS_LEFT: begin
                        st_nxt.collecting = 1'b1;
                        st_nxt.need       = NPAR_SCROLL;
                    end
                    default: begin
                        if (byteIn[7:4] == NIB_COL_LO) begin
                            st_nxt.pageCol[3:0] = byteIn[3:0];
                        end else if (byteIn[7:3] == PFX_COL_HI) begin
                            st_nxt.pageCol[6:4] = byteIn[2:0];
                        end else if (byteIn[7:4] == NIB_LINE) begin
                            st_nxt.startLine = byteIn[3:0];
                        end else if (byteIn[7:1] == PFX_ENTIRE) begin
                            st_nxt.entireOn = byteIn[0];
                        end else if (byteIn[7:1] == PFX_PAGE) begin
                            st_nxt.pagePage = byteIn[0];
                        end else if (byteIn[7:5] == PFX_FUNC_SET) begin
                            st_nxt.extSel = byteIn[FUNC_EXT_BIT];
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r            <= '0;
            st_r.waitReq    <= 1'b1;
            st_r.charMode   <= 1'b1;
            st_r.addrMode   <= AM_PAGE;
            st_r.colEnd     <= COL_END_RST;
            st_r.pageEnd    <= 1'b1;
            st_r.scrollRows <= ROWS_RST;
            st_r.frames     <= FRAMES_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign waitrequest = st_r.waitReq;
    assign readdata    = st_r.rdData;
    assign charMode    = st_r.charMode;
    assign entireOn    = st_r.entireOn;
    assign contentStep = st_r.contentStep;
    assign contentLeft = st_r.contentLeft;
    assign stepFrames  = st_r.frames;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_param_for(logic [7:0] op);
        byteTake && !dcIn && st_r.collecting && st_r.opcode == op
            && st_r.idx + 3'h1 == st_r.need;
    endsequence

    a_mode_select: assert property (s_param_for(OP_MODE_SEL) |=>
        charMode == $past(writedata[0])) else $error("mode select not applied");
    a_addr_mode: assert property (s_param_for(OP_ADDR_MODE) |=>
        st_r.addrMode == ($past(writedata[1:0]) == AM_INVALID ? $past(st_r.addrMode)
                          : $past(writedata[1:0]))) else $error("addressing mode wrong");
    a_area_limit: assert property ({2'b00, st_r.fixedRows} + {1'b0, st_r.scrollRows}
        <= MUX_LIMIT) else $error("scroll area exceeds multiplex ratio");
    a_line_load: assert property (byteTake && !dcIn && st_r.unlock && !st_r.collecting
        && byteIn[7:4] == NIB_LINE |=> st_r.startLine == $past(byteIn[3:0]))
        else $error("start line not loaded");
    a_locked_refuse: assert property (byteTake && !st_r.unlock && !st_r.collecting
        |=> $stable(st_r.startLine) && $stable(st_r.entireOn) && !st_r.collecting)
        else $error("locked interface took a graphic command");
    a_unlock_ctrl: assert property (byteTake && !dcIn && !st_r.collecting && st_r.extSel
        && byteIn[7:1] == PFX_UNLOCK |=> st_r.unlock == $past(byteIn[0]))
        else $error("unlock bit not updated");
    a_step_map: assert property (st_r.frames == step_frames(st_r.interval)
        || $past(rst)) else $error("frame count does not match interval");
    a_content_pulse: assert property (s_param_for(OP_CS_LEFT) |=>
        contentStep && contentLeft ##1 !contentStep) else $error("content shift pulse wrong");
    a_entire_disp: assert property (byteTake && !dcIn && st_r.unlock && !st_r.collecting
        && byteIn[7:1] == PFX_ENTIRE |=> entireOn == $past(byteIn[0]))
        else $error("entire display not set");
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1
        waitrequest) else $error("bus answer not one cycle after request");

    // ************************************************************
    // single-byte and completion checks
    // ************************************************************
    // a command byte seen by the unlocked decoder outside a parameter run
    sequence s_cmd_byte(logic hit);
        byteTake && !dcIn && st_r.unlock && !st_r.collecting
            && hit;
    endsequence

    // page-mode column and page loads
    a_col_low: assert property (s_cmd_byte(byteIn[7:4] == NIB_COL_LO) |=>
        st_r.pageCol[3:0] == $past(byteIn[3:0]))
        else $error("low column nibble not loaded");
    a_col_high: assert property (s_cmd_byte(byteIn[7:3] == PFX_COL_HI) |=>
        st_r.pageCol[6:4] == $past(byteIn[2:0]))
        else $error("high column bits not loaded");
    a_page_pick: assert property (s_cmd_byte(byteIn[7:1] == PFX_PAGE) |=>
        st_r.pagePage == $past(byteIn[0]))
        else $error("page-mode start page not loaded");

    // windows and offset applied on the last parameter
    a_col_window: assert property (s_param_for(OP_COL_ADDR) |=>
        st_r.colStart == $past(st_r.pbuf[0][6:0])
        && st_r.colEnd == $past(byteIn[6:0]))
        else $error("column window not applied");
    a_page_window: assert property (s_param_for(OP_PAGE_ADDR) |=>
        st_r.pageStart == $past(st_r.pbuf[0][0])
        && st_r.pageEnd == $past(byteIn[0]))
        else $error("page window not applied");
    a_disp_shift: assert property (s_param_for(OP_OFFSET) |=>
        st_r.dispOffset == $past(byteIn[3:0]))
        else $error("display offset not applied");

    // scroll setups: direction and horizontal offset
    a_hscroll_dir: assert property (s_param_for(OP_HS_LEFT) |=>
        st_r.scrollLeft && st_r.hOffset)
        else $error("left scroll setup wrong");
    a_vh_offset: assert property (s_param_for(OP_VH_RIGHT) |=>
        !st_r.scrollLeft && st_r.hOffset == $past(st_r.pbuf[0][0]))
        else $error("combined scroll offset wrong");
    a_content_right: assert property (s_param_for(OP_CS_RIGHT) |=>
        contentStep && !contentLeft)
        else $error("right content shift wrong");

    // data bytes leave the decoder untouched
    a_data_ignore: assert property (byteTake && dcIn |=>
        $stable(st_r.idx) && $stable(st_r.collecting) && $stable(st_r.entireOn))
        else $error("data byte changed decoder state");
endmodule : oled_graphic_command_decoder
`default_nettype wire
